// File: common/ibg_bus_if.sv
// Pin-level bus between the processor end and the peripheral/DMA end.
// Works out shared wire levels from the output enables; floated lines read high.
interface ibg_bus_if;
    logic [31:0] addrOut;
    logic [31:0] cpuData;
    logic cpuDataOeN;
    logic cpuBusOeN;
    logic addrStrobeN;
    logic dataStrobeN;
    logic cycleBeginN;
    logic cpuDataLatchedN;
    logic [3:0] accessStatusCode;
    logic [2:0] transferSize;
    logic readWriteN;
    logic [1:0] execLevelOut;
    logic virtAddrFlagN;
    logic abortN;
    logic busGrantAckN;
    logic resetAckN;
    logic rrAckOeN;
    logic [3:0] priorityRequestIn;
    logic intrOptionIn;
    logic selfVectorInN;
    logic nonmaskIntrInN;
    logic fullXferAckN;
    logic halfwidthXferAckN;
    logic faultN;
    logic retryN;
    logic relinquishRetryReqN;
    logic busGrantReqN;
    logic [31:0] periphData;
    logic periphDataOeN;
    logic [31:0] dataBus;
    logic [31:0] addrBus;
    logic [3:0] sasBus;
    logic asBus;
    logic relinquishRetryAckN;

    assign dataBus = !cpuDataOeN ? cpuData : (!periphDataOeN ? periphData : '1);
    assign addrBus = cpuBusOeN ? '1 : addrOut;
    assign sasBus = cpuBusOeN ? '1 : accessStatusCode;
    assign asBus = cpuBusOeN | addrStrobeN;
    assign relinquishRetryAckN = rrAckOeN;

    modport cpu (
        output addrOut, cpuData, cpuDataOeN, cpuBusOeN, addrStrobeN, dataStrobeN,
        output cycleBeginN, cpuDataLatchedN, accessStatusCode, transferSize, readWriteN,
        output execLevelOut, virtAddrFlagN, abortN, busGrantAckN, resetAckN, rrAckOeN,
        input priorityRequestIn, intrOptionIn, selfVectorInN, nonmaskIntrInN,
        input fullXferAckN, halfwidthXferAckN, faultN, retryN, relinquishRetryReqN,
        input busGrantReqN, dataBus
    );
    modport periph (
        output priorityRequestIn, intrOptionIn, selfVectorInN, nonmaskIntrInN,
        output fullXferAckN, halfwidthXferAckN, faultN, retryN, relinquishRetryReqN,
        output busGrantReqN, periphData, periphDataOeN,
        input addrBus, sasBus, asBus, busGrantAckN, relinquishRetryAckN
    );
endinterface : ibg_bus_if

// File: common/ibg_pkg.sv
// Shared constants and types for the interrupt-acknowledge and bus-grant logic.
// Assumes one clock (sys_clk) and active-low asynchronous reset (rstn) on both ends.
package ibg_pkg;
    localparam int IBG_AW = 32;
    localparam int IBG_DW = 32;
    localparam int IBG_LVL_LSB = 2;
    localparam int IBG_OPT_BIT = 6;
    localparam logic [3:0] IBG_NO_INT = 4'hF;
    localparam logic [1:0] IBG_VECT_LOW = 2'h3;
    localparam logic [3:0] IBG_SAS_INT_ACK = 4'hE;
    localparam logic [3:0] IBG_SAS_AUTOVEC_ACK = 4'hC;
    localparam logic [2:0] IBG_SIZE_BYTE = 3'h2;
    localparam logic [7:0] IBG_NMI_VECTOR = 8'h00;
    localparam logic [31:0] IBG_NMI_ADDR = 32'h0000_0000;
    localparam logic [1:0] IBG_EXEC_RST = 2'h0;

    typedef enum {
        ST_IDLE, ST_ADDR, ST_STROBE, ST_LAST, ST_FLOAT, ST_GRANT,
        ST_RELEASE, ST_RR_FLOAT, ST_RR_ACK, ST_RETRY_WAIT
    } ibg_state_t;

    typedef enum {K_CORE, K_VECT, K_AUTO, K_NMI} ibg_kind_t;
endpackage : ibg_pkg

// File: dv/ibg_props.sv
// Pin-level checker for the bus joining the processor end and the peripheral end.
// Instantiated by the bench beside the interface; one clock, reset rstn active low.
module ibg_props
    import ibg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [31:0] addrOut,
    input wire logic cpuBusOeN,
    input wire logic cpuDataOeN,
    input wire logic addrStrobeN,
    input wire logic cpuDataLatchedN,
    input wire logic [3:0] accessStatusCode,
    input wire logic [2:0] transferSize,
    input wire logic busGrantAckN,
    input wire logic resetAckN,
    input wire logic rrAckOeN,
    input wire logic [3:0] priorityRequestIn,
    input wire logic intrOptionIn,
    input wire logic nonmaskIntrInN,
    input wire logic fullXferAckN,
    input wire logic halfwidthXferAckN,
    input wire logic periphDataOeN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic strobeQ;
    logic vecGo;
    logic avGo;
    // Strobe falling edge starts the data phase of an acknowledge
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) strobeQ <= 1'b1;
        else strobeQ <= addrStrobeN;
    end
    assign vecGo = strobeQ && !addrStrobeN && accessStatusCode == IBG_SAS_INT_ACK;
    assign avGo = strobeQ && !addrStrobeN && accessStatusCode == IBG_SAS_AUTOVEC_ACK;
    property p_lvl; (vecGo || (avGo && addrOut[0]))
        |-> addrOut[5:2] == ~priorityRequestIn; endproperty
    a_lvl: assert property (p_lvl) else $error("ack level bits wrong");
    property p_opt; (vecGo || (avGo && addrOut[0])) |-> addrOut[6] == ~intrOptionIn; endproperty
    a_opt: assert property (p_opt) else $error("ack option bit wrong");
    property p_vfmt; vecGo |-> addrOut[31:7] == 25'h0 && addrOut[1:0] == IBG_VECT_LOW
        && transferSize == IBG_SIZE_BYTE && addrOut[5:2] != 4'h0; endproperty
    a_vfmt: assert property (p_vfmt) else $error("vectored ack format wrong");
    property p_nmi; strobeQ && !addrStrobeN && !nonmaskIntrInN
        |-> accessStatusCode == IBG_SAS_AUTOVEC_ACK && addrOut == IBG_NMI_ADDR; endproperty
    a_nmi: assert property (p_nmi) else $error("nonmaskable ack wrong");
    property p_fixed; avGo |-> cpuDataLatchedN
        ##1 (addrStrobeN && cpuDataLatchedN) [*2]; endproperty
    a_fixed: assert property (p_fixed) else $error("autovector cycle not fixed");
    property p_answer; vecGo |-> ##[1:20] (!fullXferAckN || !halfwidthXferAckN) && !periphDataOeN;
    endproperty
    a_answer: assert property (p_answer) else $error("no vector answer");
    property p_withdraw; vecGo |-> ##[1:20] priorityRequestIn == IBG_NO_INT; endproperty
    a_withdraw: assert property (p_withdraw) else $error("level not withdrawn");
    property p_nmirel; avGo && addrOut == IBG_NMI_ADDR |-> ##[1:20] nonmaskIntrInN; endproperty
    a_nmirel: assert property (p_nmirel) else $error("nonmaskable not released");
    property p_granted; !busGrantAckN |-> cpuBusOeN && cpuDataOeN && resetAckN && rrAckOeN;
    endproperty
    a_granted: assert property (p_granted) else $error("bus held while granted");
    property p_float; $rose(cpuBusOeN)
        |-> busGrantAckN ##1 (!busGrantAckN || !rrAckOeN); endproperty
    a_float: assert property (p_float) else $error("grant not one cycle after float");
    property p_reclaim; $rose(busGrantAckN) |-> cpuBusOeN ##1 !cpuBusOeN; endproperty
    a_reclaim: assert property (p_reclaim) else $error("bus reclaimed out of order");
    c_vect: cover property (vecGo);
    c_nmi: cover property (avGo && addrOut == IBG_NMI_ADDR);
    c_grant: cover property ($fell(busGrantAckN));
    c_rr: cover property ($fell(rrAckOeN));
endmodule : ibg_props

// File: dv/ibg_tb.sv
// Bench joining both ends through the pin interface; drives their user sides.
// Inputs change on the falling edge; random values from a fixed seed.
module ibg_tb
    import ibg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rstn;
    logic [3:0] priorityMaskField, coreSas, irqLevel;
    logic intWindow, coreReq, coreWrite, coreLock, coreVirtual;
    logic [31:0] coreAddr, coreWdata, coreRdata;
    logic [2:0] coreSize;
    logic [1:0] coreExecLevel;
    logic coreDone, xferFault, intTaken, intNmi, busGranted;
    logic [7:0] intVector, irqVector;
    logic irqRaise, irqOption, irqSelfVector, useHalfAck, nmiRaise, dmaReq, relinquish_retry_req;
    logic retryReq, faultReq, irqPending, nmiPending, dmaGranted, rrGranted;
    int seed = 18503;
    int nFail = 0;
    int testsRun = 0;
    ibg_bus_if bus ();
    ibg_cpu_end ibg_cpu_end_i (.sys_clk, .rstn, .bus, .priorityMaskField, .intWindow, .coreReq,
        .coreWrite, .coreLock, .coreAddr, .coreWdata, .coreSas, .coreSize, .coreExecLevel,
        .coreVirtual, .coreDone, .xferFault, .coreRdata, .intTaken, .intNmi, .intVector,
        .busGranted);
    ibg_periph_end ibg_periph_end_i (.sys_clk, .rstn, .bus, .irqRaise, .irqLevel, .irqOption,
        .irqSelfVector, .irqVector, .useHalfAck, .nmiRaise, .dmaReq, .relinquish_retry_req, .retryReq,
        .faultReq, .irqPending, .nmiPending, .dmaGranted, .rrGranted);
    ibg_props ibg_props_i (.sys_clk, .rstn, .addrOut(bus.addrOut), .cpuBusOeN(bus.cpuBusOeN),
        .cpuDataOeN(bus.cpuDataOeN), .addrStrobeN(bus.addrStrobeN),
        .cpuDataLatchedN(bus.cpuDataLatchedN), .accessStatusCode(bus.accessStatusCode),
        .transferSize(bus.transferSize), .busGrantAckN(bus.busGrantAckN),
        .resetAckN(bus.resetAckN), .rrAckOeN(bus.rrAckOeN),
        .priorityRequestIn(bus.priorityRequestIn), .intrOptionIn(bus.intrOptionIn),
        .nonmaskIntrInN(bus.nonmaskIntrInN), .fullXferAckN(bus.fullXferAckN),
        .halfwidthXferAckN(bus.halfwidthXferAckN), .periphDataOeN(bus.periphDataOeN));
    always #4 sys_clk = ~sys_clk;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nFail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wait_on(ref logic s, input logic lvl, input string what);
        int n;
        n = 0;
        while (s !== lvl && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        check(what, s, lvl);
    endtask : wait_on
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    function automatic logic [7:0] exp_vector(input logic [3:0] lvl, input logic opt,
            input logic sv, input logic [7:0] vec);
        return sv ? {3'h0, ~opt, lvl} : vec;
    endfunction : exp_vector
    // One interrupt; blk means the level starts masked and the mask is lowered later
    task automatic irq(input logic [3:0] lvl, input logic opt, input logic sv, input bit blk);
        logic [7:0] vec;
        logic hit;
        vec = $random(seed);
        hit = 1'b0;
        @(negedge sys_clk);
        {irqLevel, irqOption, irqSelfVector, irqVector, irqRaise} = {lvl, opt, sv, vec, 1'b1};
        useHalfAck = $random(seed);
        @(negedge sys_clk);
        irqRaise = 1'b0;
        if (blk) begin
            repeat (20) begin
                @(negedge sys_clk);
                if (intTaken === 1'b1) hit = 1'b1;
            end
            check("maskedTaken", hit, 1'b0);
            priorityMaskField = 4'h0;
        end
        wait_on(intTaken, 1'b1, "intTaken");
        @(negedge sys_clk);
        check("intVector", intVector, exp_vector(lvl, opt, sv, vec));
        check("intNmi", intNmi, 1'b0);
        wait_on(irqPending, 1'b0, "irqWithdrawn");
        repeat (24) @(negedge sys_clk);
    endtask : irq
    // Core write: relinquish (rr) or retry first, then fault, with a bus request pending
    task automatic core(input bit rr);
        @(negedge sys_clk);
        {coreAddr, coreWdata, coreWrite} = {$random(seed), $random(seed), 1'b1};
        {coreSize, coreExecLevel, coreVirtual} = $random(seed);
        coreSas = $random(seed) & 4'h7;
        coreReq = 1'b1;
        repeat (4) @(negedge sys_clk);
        dmaReq = 1'b1;
        {relinquish_retry_req, retryReq} = {rr, !rr};
        repeat (10) @(negedge sys_clk);
        check("rrGranted", rrGranted, rr);
        check("dmaBeforeRetry", dmaGranted, 1'b0);
        {relinquish_retry_req, retryReq} = 2'b00;
        repeat (8) @(negedge sys_clk);
        faultReq = 1'b1;
        wait_on(coreDone, 1'b1, "coreDone");
        check("grantEarly", busGranted, 1'b0);
        @(negedge sys_clk);
        {coreReq, faultReq} = 2'b00;
        check("xferFault", xferFault, 1'b1);
        wait_on(dmaGranted, 1'b1, "dmaGranted");
        check("busGranted", busGranted, 1'b1);
        dmaReq = 1'b0;
        wait_on(busGranted, 1'b0, "grantDropped");
        repeat (8) @(negedge sys_clk);
    endtask : core
    initial begin
        rstn = 1'b0;
        {priorityMaskField, intWindow, coreReq, coreWrite, coreLock, coreVirtual} = '0;
        {coreAddr, coreWdata, coreSas, coreSize, coreExecLevel} = '0;
        {irqRaise, irqOption, irqSelfVector, useHalfAck, nmiRaise, dmaReq, relinquish_retry_req} = '0;
        {retryReq, faultReq, irqLevel, irqVector} = '0;
        repeat (4) @(negedge sys_clk);
        rstn = 1'b1;
        intWindow = 1'b1;
        repeat (8) @(negedge sys_clk);
        irq(4'h0, 1'b0, 1'b0, 1'b0);
        irq(4'hE, 1'b1, 1'b1, 1'b0);
        repeat (8) irq(($random(seed) & 32'hFF) % 15, $random(seed), $random(seed), 1'b0);
        priorityMaskField = 4'h5;
        irq(4'hA, 1'b0, 1'b0, 1'b1);
        priorityMaskField = 4'hF;
        nmiRaise = 1'b1;
        @(negedge sys_clk);
        nmiRaise = 1'b0;
        wait_on(intTaken, 1'b1, "nmiTaken");
        @(negedge sys_clk);
        check("nmiFlag", intNmi, 1'b1);
        check("nmiVector", intVector, IBG_NMI_VECTOR);
        wait_on(nmiPending, 1'b0, "nmiReleased");
        core(1'b0);
        core(1'b1);
        dmaReq = 1'b1;
        wait_on(dmaGranted, 1'b1, "idleGrant");
        dmaReq = 1'b0;
        wait_on(busGranted, 1'b0, "idleRelease");
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        nFail++;
        give_verdict();
    end
endmodule : ibg_tb

// File: rtl/ibg_cpu_end.sv
// Processor end: interrupt acknowledge cycles and bus arbitration.
// Assumes the core holds coreReq and its fields stable until coreDone.
module ibg_cpu_end
    import ibg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    ibg_bus_if.cpu bus,
    input wire logic [3:0] priorityMaskField,
    input wire logic intWindow,
    input wire logic coreReq,
    input wire logic coreWrite,
    input wire logic coreLock,
    input wire logic [31:0] coreAddr,
    input wire logic [31:0] coreWdata,
    input wire logic [3:0] coreSas,
    input wire logic [2:0] coreSize,
    input wire logic [1:0] coreExecLevel,
    input wire logic coreVirtual,
    output logic coreDone,
    output logic xferFault,
    output logic [31:0] coreRdata,
    output logic intTaken,
    output logic intNmi,
    output logic [7:0] intVector,
    output logic busGranted
);
    logic [3:0] iplQ;
    logic optQ;
    logic avecNQ;
    logic fullAckNQ;
    logic halfAckNQ;
    logic faultNQ;
    logic retryNQ;
    logic rrReqNQ;
    logic busReqNQ;
    logic nmiNQ;
    logic [31:0] dataQ;
    ibg_state_t state;
    ibg_state_t next_state;
    ibg_kind_t kind;
    ibg_kind_t startKind;
    logic lockPend;
    logic nmiArmed;
    logic [3:0] intLevel;
    logic [31:0] startAddr;
    logic intTake;
    logic nmiTake;
    logic ack;
    logic fixedLen;
    logic busReq;
    logic rrAct;
    logic quiet;
    logic writeNow;

    ibg_sync #(.W(6), .AGREE(1'b1), .INIT(6'h3F)) u_intSync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .din({bus.intrOptionIn, bus.selfVectorInN, bus.priorityRequestIn}),
        .dout({optQ, avecNQ, iplQ})
    );

    ibg_sync #(.W(39), .AGREE(1'b0), .INIT('1)) u_busSync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .din({bus.fullXferAckN, bus.halfwidthXferAckN, bus.faultN, bus.retryN,
              bus.relinquishRetryReqN, bus.busGrantReqN, bus.nonmaskIntrInN, bus.dataBus}),
        .dout({fullAckNQ, halfAckNQ, faultNQ, retryNQ, rrReqNQ, busReqNQ, nmiNQ, dataQ})
    );

    assign ack = !fullAckNQ || !halfAckNQ;
    assign fixedLen = (kind == K_AUTO) || (kind == K_NMI);
    assign busReq = !busReqNQ;
    assign quiet = fixedLen || (fullAckNQ && halfAckNQ && faultNQ && retryNQ);
    // Write half of a locked pair does not honour relinquish requests
    assign rrAct = !rrReqNQ && !(kind == K_CORE && !bus.readWriteN && lockPend);
    assign nmiTake = !nmiNQ && nmiArmed;
    // Masked levels and the idle code never start an acknowledge
    assign intTake = (iplQ != IBG_NO_INT) && (iplQ != intLevel)
                     && ((~iplQ) > priorityMaskField);

    always_comb begin
        if (nmiTake) begin
            startKind = K_NMI;
        end else if (intTake) begin
            startKind = avecNQ ? K_VECT : K_AUTO;
        end else begin
            startKind = K_CORE;
        end
        case (startKind)
            K_NMI: startAddr = IBG_NMI_ADDR;
            K_CORE: startAddr = coreAddr;
            default: startAddr = {25'h0, ~optQ, ~iplQ, IBG_VECT_LOW};
        endcase
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (busReq && !lockPend) begin
                    next_state = ST_FLOAT;
                end else if (intWindow && (nmiTake || intTake)) begin
                    next_state = ST_ADDR;
                end else if (coreReq) begin
                    next_state = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (quiet) begin
                    next_state = ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (fixedLen) begin
                    next_state = ST_LAST;
                end else if (rrAct) begin
                    next_state = ST_RR_FLOAT;
                end else if (!retryNQ) begin
                    next_state = ST_RETRY_WAIT;
                end else if (!faultNQ || ack) begin
                    next_state = ST_LAST;
                end
            end
            ST_LAST: begin
                if (busReq && !lockPend) begin
                    next_state = ST_FLOAT;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_FLOAT: next_state = ST_GRANT;
            ST_GRANT: begin
                if (!busReq) begin
                    next_state = ST_RELEASE;
                end
            end
            ST_RELEASE: next_state = ST_IDLE;
            ST_RR_FLOAT: next_state = ST_RR_ACK;
            ST_RR_ACK: begin
                if (rrReqNQ) begin
                    next_state = ST_ADDR;
                end
            end
            ST_RETRY_WAIT: begin
                if (retryNQ) begin
                    next_state = ST_ADDR;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Transaction set-up, held unchanged across retries
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            kind <= K_CORE;
            bus.addrOut <= '0;
            bus.cpuData <= '0;
            bus.accessStatusCode <= '1;
            bus.transferSize <= '0;
            bus.readWriteN <= 1'b1;
            bus.execLevelOut <= IBG_EXEC_RST;
            bus.virtAddrFlagN <= 1'b1;
        end else if (state == ST_IDLE && next_state == ST_ADDR) begin
            kind <= startKind;
            bus.addrOut <= startAddr;
            bus.cpuData <= coreWdata;
            bus.execLevelOut <= coreExecLevel;
            bus.virtAddrFlagN <= (startKind == K_CORE) ? !coreVirtual : 1'b1;
            if (startKind == K_CORE) begin
                bus.accessStatusCode <= coreSas;
                bus.transferSize <= coreSize;
                bus.readWriteN <= !coreWrite;
            end else begin
                bus.accessStatusCode <= (startKind == K_VECT) ? IBG_SAS_INT_ACK
                                                               : IBG_SAS_AUTOVEC_ACK;
                bus.transferSize <= IBG_SIZE_BYTE;
                bus.readWriteN <= 1'b1;
            end
        end
    end

    assign writeNow = (state == ST_IDLE) ? (startKind == K_CORE && coreWrite) : !bus.readWriteN;

    // Pin strobes and enables follow the next state
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bus.cycleBeginN <= 1'b1;
            bus.addrStrobeN <= 1'b1;
            bus.dataStrobeN <= 1'b1;
            bus.cpuDataLatchedN <= 1'b1;
            bus.cpuDataOeN <= 1'b1;
            bus.cpuBusOeN <= 1'b0;
            bus.busGrantAckN <= 1'b1;
        end else begin
            bus.cycleBeginN <= !(next_state == ST_ADDR && state != ST_ADDR);
            bus.addrStrobeN <= !(next_state == ST_STROBE);
            bus.dataStrobeN <= !(next_state == ST_STROBE);
            bus.cpuDataLatchedN <= !(state == ST_STROBE && next_state == ST_LAST && !fixedLen
                                     && ack && faultNQ && bus.readWriteN);
            bus.cpuDataOeN <= !(writeNow && (next_state == ST_ADDR || next_state == ST_STROBE));
            bus.cpuBusOeN <= (next_state == ST_FLOAT) || (next_state == ST_GRANT)
                             || (next_state == ST_RELEASE) || (next_state == ST_RR_FLOAT)
                             || (next_state == ST_RR_ACK);
            bus.busGrantAckN <= !(next_state == ST_GRANT);
        end
    end

    assign bus.abortN = 1'b1;
    assign bus.resetAckN = 1'b1;
    assign bus.rrAckOeN = !(state == ST_RR_ACK);

    // Results for the core
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            coreRdata <= '0;
            intVector <= '0;
            xferFault <= 1'b0;
        end else begin
            if (state == ST_IDLE && next_state == ST_ADDR) begin
                xferFault <= 1'b0;
                if (startKind == K_NMI) begin
                    intVector <= IBG_NMI_VECTOR;
                end else if (startKind == K_AUTO) begin
                    intVector <= {3'h0, ~optQ, iplQ};
                end
            end
            if (state == ST_STROBE && next_state == ST_LAST && !fixedLen) begin
                xferFault <= !faultNQ;
                if (kind == K_VECT) begin
                    intVector <= dataQ[7:0];
                end else begin
                    coreRdata <= dataQ;
                end
            end
        end
    end

    // Lock tracking and one-shot arming of interrupt sources
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lockPend <= 1'b0;
            nmiArmed <= 1'b1;
            intLevel <= IBG_NO_INT;
        end else begin
            if (state == ST_STROBE && next_state == ST_LAST && kind == K_CORE) begin
                lockPend <= coreLock && bus.readWriteN;
            end
            if (state == ST_IDLE && next_state == ST_ADDR && startKind == K_NMI) begin
                nmiArmed <= 1'b0;
            end else if (nmiNQ) begin
                nmiArmed <= 1'b1;
            end
            if (state == ST_IDLE && next_state == ST_ADDR
                && (startKind == K_VECT || startKind == K_AUTO)) begin
                intLevel <= iplQ;
            end else if (iplQ == IBG_NO_INT) begin
                intLevel <= IBG_NO_INT;
            end
        end
    end

    assign coreDone = (state == ST_LAST) && (kind == K_CORE);
    assign intTaken = (state == ST_LAST) && (kind != K_CORE);
    assign intNmi = (kind == K_NMI);
    assign busGranted = (state == ST_GRANT);
endmodule : ibg_cpu_end

// File: rtl/ibg_periph_end.sv
// Peripheral and DMA end: raises interrupts, answers acknowledges, requests the bus.
// Assumes user controls are synchronous to sys_clk; bus pins are synchronised here.
module ibg_periph_end
    import ibg_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    ibg_bus_if.periph bus,
    input wire logic irqRaise,
    input wire logic [3:0] irqLevel,
    input wire logic irqOption,
    input wire logic irqSelfVector,
    input wire logic [7:0] irqVector,
    input wire logic useHalfAck,
    input wire logic nmiRaise,
    input wire logic dmaReq,
    input wire logic relinquish_retry_req,
    input wire logic retryReq,
    input wire logic faultReq,
    output logic irqPending,
    output logic nmiPending,
    output logic dmaGranted,
    output logic rrGranted
);
    logic [31:0] addrQ;
    logic [3:0] sasQ;
    logic asNQ;
    logic grantNQ;
    logic rrAckNQ;
    logic [3:0] lvl;
    logic vectHit;
    logic autoHit;
    logic nmiHit;
    logic answering;

    ibg_sync #(.W(39), .AGREE(1'b0), .INIT('1)) u_pinSync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .din({bus.addrBus, bus.sasBus, bus.asBus, bus.busGrantAckN, bus.relinquishRetryAckN}),
        .dout({addrQ, sasQ, asNQ, grantNQ, rrAckNQ})
    );

    assign vectHit = irqPending && !asNQ && sasQ == IBG_SAS_INT_ACK && addrQ[1:0] == IBG_VECT_LOW
                     && addrQ[IBG_LVL_LSB +: 4] == ~lvl;
    assign autoHit = irqPending && !asNQ && sasQ == IBG_SAS_AUTOVEC_ACK && addrQ[0]
                     && addrQ[IBG_LVL_LSB +: 4] == ~lvl;
    assign nmiHit = nmiPending && !asNQ && sasQ == IBG_SAS_AUTOVEC_ACK && addrQ == IBG_NMI_ADDR;

    // Request state: level withdrawn once its acknowledge is seen
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irqPending <= 1'b0;
            nmiPending <= 1'b0;
            lvl <= IBG_NO_INT;
        end else begin
            if (irqRaise) begin
                irqPending <= 1'b1;
                lvl <= irqLevel;
            end else if (vectHit || autoHit) begin
                irqPending <= 1'b0;
            end
            if (nmiRaise) begin
                nmiPending <= 1'b1;
            end else if (nmiHit) begin
                nmiPending <= 1'b0;
            end
        end
    end

    // Vector answer held until the address strobe goes away
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            answering <= 1'b0;
            bus.periphData <= '0;
        end else if (vectHit) begin
            answering <= 1'b1;
            bus.periphData <= {24'h0, irqVector};
        end else if (asNQ) begin
            answering <= 1'b0;
        end
    end

    // Pin drive
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            bus.priorityRequestIn <= IBG_NO_INT;
            bus.intrOptionIn <= 1'b1;
            bus.selfVectorInN <= 1'b1;
            bus.nonmaskIntrInN <= 1'b1;
            bus.busGrantReqN <= 1'b1;
            bus.relinquishRetryReqN <= 1'b1;
            bus.retryN <= 1'b1;
            bus.faultN <= 1'b1;
        end else begin
            bus.priorityRequestIn <= (irqPending && !(vectHit || autoHit)) ? lvl : IBG_NO_INT;
            bus.intrOptionIn <= irqOption;
            bus.selfVectorInN <= !(irqPending && irqSelfVector);
            bus.nonmaskIntrInN <= !(nmiPending && !nmiHit);
            bus.busGrantReqN <= !dmaReq;
            bus.relinquishRetryReqN <= !relinquish_retry_req;
            bus.retryN <= !retryReq;
            bus.faultN <= !faultReq;
        end
    end

    assign bus.periphDataOeN = !answering;
    assign bus.fullXferAckN = !(answering && !useHalfAck);
    assign bus.halfwidthXferAckN = !(answering && useHalfAck);
    assign dmaGranted = !grantNQ;
    assign rrGranted = !rrAckNQ;
endmodule : ibg_periph_end

// File: rtl/ibg_sync.sv
// Two-flop synchroniser; with AGREE set, a new value passes only when two
// consecutive synchronised samples match. Assumes inputs are asynchronous pins.
module ibg_sync #(
    parameter int W = 1,
    parameter bit AGREE = 1'b0,
    parameter logic [W-1:0] INIT = '1
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stage1 <= INIT;
            stage2 <= INIT;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
        end
    end

    generate
        if (AGREE) begin : g_agree
            logic [W-1:0] stage3;
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    stage3 <= INIT;
                    dout <= INIT;
                end else begin
                    stage3 <= stage2;
                    if (stage2 == stage3) begin
                        dout <= stage2;
                    end
                end
            end
        end else begin : g_plain
            assign dout = stage2;
        end
    endgenerate
endmodule : ibg_sync
